// File: logic/mgmt_interrupt_idle_timers.sv
// What this block does
// - gate set: any request asserts interrupt output
// - gate clear negates; re-gate re-asserts pending
// - gate clear wins over simultaneous set
// - trap interrupt precedes ready by three clocks
// - enable write starts idle countdown from count
// - idle timer decrements per eight-second tick
// - idle expiry raises request, sets status
// - idle reloads on enable, expiry, events
// - global event enable off blocks event reloads
// - per-class enables select reloading event classes
// - system activity pin always reloads timers
// - freeze holds idle countdown
// - software standby flag, no hardware effect
// - group enable gates pin and software sources
// - both sources share one delay timer
// - enabled external pin starts delay countdown
// - software request bit starts delay countdown
// - delay count in one-millisecond units
// - delay timer reloads on same events
// - delay expiry raises interrupt, sets group status
// - fire sets per-source flags, both if both
`timescale 1ns/100ps
module mgmt_interrupt_idle_timers #(
  parameter int unsigned MS_CYCLES    = mgmt_timer_pkg::MS_CYCLES,
  parameter int unsigned SLOW_TICK_MS = mgmt_timer_pkg::SLOW_TICK_MS
) (
  input  wire logic                       mclk,
  input  wire logic                       rst_n,
  input  wire mgmt_timer_pkg::ctrl_t      ctrl,
  input  wire logic                       software_request_bit,
  input  wire logic                       standby_flag_we,
  input  wire logic                       standby_flag_wdata,
  input  wire logic [7:0]                 idle_init_count,
  input  wire logic [7:0]                 delay_init_count,
  input  wire mgmt_timer_pkg::reload_en_t reload_en,
  input  wire logic [15:0]                irq_lines,
  input  wire logic                       cpu_intr,
  input  wire logic                       nmi,
  input  wire logic                       serial_ring_indicate_pin_n,
  input  wire logic                       battery_low_pin_n,
  input  wire logic                       suspend_resume_button_pin_n,
  input  wire logic                       system_activity_pin_n,
  input  wire logic                       external_request_pin_n,
  input  wire logic                       hw_mgmt_request,
  input  wire logic                       local_trap_request,
  input  wire mgmt_timer_pkg::status_t    status_clear,
  output logic                            mgmt_int_out_n,
  output mgmt_timer_pkg::status_t         status,
  output logic                            standby_state_flag,
  output logic [7:0]                      idle_count,
  output logic [7:0]                      delay_count
);

  logic                       tick_ms;
  logic                       tick_slow;
  logic                       event_hit;
  logic                       reload_evt;
  logic                       idle_en_d_reg;
  logic                       idle_run_reg;
  logic                       idle_start;
  logic                       idle_step;
  logic                       idle_expire;
  logic                       ext_req;
  logic                       sw_req;
  logic                       pend_ext_reg;
  logic                       pend_sw_reg;
  logic                       dly_fire;
  logic                       req_pending;
  logic [3:0]                 status_reg;
  logic [3:0]                 status_set;
  mgmt_timer_pkg::dly_state_t dly_state_reg;

  tick_divider #(
    .MS_CYCLES    (MS_CYCLES),
    .SLOW_TICK_MS (SLOW_TICK_MS)
  ) u_ticks (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .tick_ms   (tick_ms),
    .tick_slow (tick_slow)
  );

  // activity events that restart both timers
  always_comb begin
    event_hit = (reload_en.irq_line_reload_enable
                  & (|(irq_lines & mgmt_timer_pkg::IRQ_EVENT_MASK)))
              | (reload_en.cpu_intr_reload_enable & cpu_intr)
              | (reload_en.ring_indicate_reload_enable & ~serial_ring_indicate_pin_n)
              | (reload_en.nonmaskable_reload_enable & nmi)
              | (reload_en.suspend_pins_reload_enable
                  & (~battery_low_pin_n | ~suspend_resume_button_pin_n))
              | (reload_en.mgmt_int_reload_enable & ~mgmt_int_out_n)
              | (reload_en.ext_request_reload_enable & ~external_request_pin_n);
    reload_evt = (reload_en.activity_event_global_enable & event_hit)
               | ~system_activity_pin_n;
  end

  // idle timer
  assign idle_start  = ctrl.idle_timer_int_enable & ~idle_en_d_reg;
  assign idle_step   = idle_run_reg & ctrl.idle_timer_int_enable & tick_slow
                     & ~ctrl.countdown_freeze;
  // a zero load expires on the first tick instead of wrapping
  assign idle_expire = idle_step & ~idle_start & ~reload_evt
                     & (idle_count <= 8'h01);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      idle_en_d_reg <= 1'b0;
    end else begin
      idle_en_d_reg <= ctrl.idle_timer_int_enable;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      idle_count   <= mgmt_timer_pkg::COUNT_RST;
      idle_run_reg <= 1'b0;
    end else if (!ctrl.idle_timer_int_enable) begin
      idle_run_reg <= 1'b0;
    end else if (idle_start || reload_evt || idle_expire) begin
      idle_count   <= idle_init_count;
      idle_run_reg <= 1'b1;
    end else if (idle_step) begin
      idle_count   <= idle_count - 8'h01;
    end
  end

  // shared delay timer for pin and software requests
  assign ext_req  = ctrl.sw_ext_group_enable & ctrl.ext_pin_request_enable
                  & ~external_request_pin_n;
  assign sw_req   = ctrl.sw_ext_group_enable & software_request_bit;
  assign dly_fire = (dly_state_reg == mgmt_timer_pkg::DLY_COUNT)
                  & ctrl.sw_ext_group_enable & ~reload_evt & tick_ms
                  & (delay_count <= 8'h01);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      dly_state_reg <= mgmt_timer_pkg::DLY_IDLE;
      delay_count   <= mgmt_timer_pkg::COUNT_RST;
    end else begin
      unique case (dly_state_reg)
        mgmt_timer_pkg::DLY_IDLE: begin
          if (ext_req || sw_req) begin
            dly_state_reg <= mgmt_timer_pkg::DLY_COUNT;
            delay_count   <= delay_init_count;
          end
        end
        mgmt_timer_pkg::DLY_COUNT: begin
          if (!ctrl.sw_ext_group_enable) begin
            dly_state_reg <= mgmt_timer_pkg::DLY_IDLE;
          end else if (reload_evt) begin
            delay_count   <= delay_init_count;
          end else if (dly_fire) begin
            dly_state_reg <= mgmt_timer_pkg::DLY_IDLE;
            delay_count   <= 8'h00;
          end else if (tick_ms) begin
            delay_count   <= delay_count - 8'h01;
          end
        end
      endcase
    end
  end

  // remember which sources asked while the timer ran
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pend_ext_reg <= 1'b0;
      pend_sw_reg  <= 1'b0;
    end else if (dly_fire || !ctrl.sw_ext_group_enable) begin
      pend_ext_reg <= 1'b0;
      pend_sw_reg  <= 1'b0;
    end else begin
      pend_ext_reg <= pend_ext_reg | ext_req;
      pend_sw_reg  <= pend_sw_reg | sw_req;
    end
  end

  // sticky status; a set in the clear cycle survives
  assign status_set = {idle_expire,
                       dly_fire,
                       dly_fire & (pend_ext_reg | ext_req),
                       dly_fire & (pend_sw_reg | sw_req)};

  for (genvar i = 0; i < 4; i++) begin : g_status
    always_ff @(posedge mclk) begin
      if (!rst_n) begin
        status_reg[i] <= mgmt_timer_pkg::STATUS_RST[i];
      end else if (status_set[i]) begin
        status_reg[i] <= 1'b1;
      end else if (status_clear[i]) begin
        status_reg[i] <= 1'b0;
      end
    end
  end

  assign status = mgmt_timer_pkg::status_t'(status_reg);

  // trap path is one register stage, far inside the three-clock margin
  assign req_pending = (status.idle_timer_status & ctrl.idle_timer_int_enable)
                     | (status.sw_ext_group_status & ctrl.sw_ext_group_enable)
                     | hw_mgmt_request | local_trap_request;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      mgmt_int_out_n <= mgmt_timer_pkg::OUT_N_RST;
    end else begin
      mgmt_int_out_n <= ~(ctrl.output_gate & req_pending);
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      standby_state_flag <= 1'b0;
    end else if (standby_flag_we) begin
      standby_state_flag <= standby_flag_wdata;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  AST_GATE_OFF: assert property (!ctrl.output_gate |=> mgmt_int_out_n)
    else $error("interrupt out while gate clear");
  AST_GATE_WINS: assert property (!ctrl.output_gate && local_trap_request
                                  |=> mgmt_int_out_n)
    else $error("set beat gate clear");
  AST_REQ_ON: assert property (ctrl.output_gate && hw_mgmt_request
                               |=> !mgmt_int_out_n)
    else $error("request not passed to output");
  AST_TRAP_FAST: assert property (ctrl.output_gate && local_trap_request
                                  |-> ##1 !mgmt_int_out_n)
    else $error("trap interrupt late");
  AST_IDLE_SET: assert property (idle_expire |=> status.idle_timer_status
                                 && idle_count == $past(idle_init_count))
    else $error("idle expiry lost");
  AST_IDLE_START: assert property (idle_start |=> idle_run_reg
                                   && idle_count == $past(idle_init_count))
    else $error("idle start did not load");
  AST_FREEZE: assert property (ctrl.countdown_freeze && !reload_evt && !idle_start
                               && ctrl.idle_timer_int_enable |=> $stable(idle_count))
    else $error("frozen idle timer moved");
  AST_SYSACT: assert property (!system_activity_pin_n && ctrl.idle_timer_int_enable
                               |=> idle_count == $past(idle_init_count))
    else $error("activity pin did not reload");
  AST_GLOBAL_OFF: assert property (!reload_en.activity_event_global_enable
                                   && system_activity_pin_n |-> !reload_evt)
    else $error("event reload with global enable clear");
  AST_GROUP_OFF: assert property (!ctrl.sw_ext_group_enable
                                  |=> dly_state_reg == mgmt_timer_pkg::DLY_IDLE)
    else $error("delay timer ran with group off");
  AST_DLY_START: assert property (dly_state_reg == mgmt_timer_pkg::DLY_IDLE && ext_req
                                  |=> dly_state_reg == mgmt_timer_pkg::DLY_COUNT
                                  && delay_count == $past(delay_init_count))
    else $error("pin request did not start delay");
  AST_FIRE: assert property (dly_fire |=> status.sw_ext_group_status)
    else $error("group status not set on fire");
  AST_BOTH: assert property (dly_fire && pend_ext_reg && pend_sw_reg
                             |=> status.ext_source_status && status.sw_source_status)
    else $error("both source flags not set");
  AST_STICKY: assert property (status.idle_timer_status && !status_clear.idle_timer_status
                               |=> status.idle_timer_status)
    else $error("status dropped without clear");

  AST_IDLE_HOLD: assert property (
    idle_run_reg && ctrl.idle_timer_int_enable && !tick_slow && !idle_start && !reload_evt
    |=> $stable(idle_count))
    else $error("idle timer moved between ticks");
  AST_IDLE_OFF: assert property (
    !ctrl.idle_timer_int_enable
    |=> !idle_run_reg && $stable(idle_count))
    else $error("idle timer ran while disabled");
  AST_GLOBAL_BLOCK: assert property (
    !reload_en.activity_event_global_enable && system_activity_pin_n && idle_step
    && !idle_start && idle_count > 8'h01 |=> idle_count == $past(idle_count) - 8'h01)
    else $error("blocked event still reloaded idle timer");
  AST_SW_START: assert property (
    dly_state_reg == mgmt_timer_pkg::DLY_IDLE && sw_req
    |=> dly_state_reg == mgmt_timer_pkg::DLY_COUNT && delay_count == $past(delay_init_count))
    else $error("software request did not start delay");
  AST_DLY_STEP: assert property (
    dly_state_reg == mgmt_timer_pkg::DLY_COUNT && ctrl.sw_ext_group_enable && !reload_evt
    && tick_ms && delay_count > 8'h01 |=> delay_count == $past(delay_count) - 8'h01)
    else $error("delay timer missed a millisecond step");
  AST_DLY_RELOAD: assert property (
    dly_state_reg == mgmt_timer_pkg::DLY_COUNT && ctrl.sw_ext_group_enable && reload_evt
    |=> delay_count == $past(delay_init_count))
    else $error("activity did not reload delay timer");
  AST_SW_FLAG: assert property (
    dly_fire && (pend_sw_reg || sw_req)
    |=> status.sw_source_status)
    else $error("software source flag not set");
  AST_EXT_FLAG: assert property (
    dly_fire && (pend_ext_reg || ext_req)
    |=> status.ext_source_status)
    else $error("pin source flag not set");
  AST_GROUP_STICKY: assert property (
    status.sw_ext_group_status && !status_clear.sw_ext_group_status
    |=> status.sw_ext_group_status)
    else $error("group status dropped without clear");
  AST_STANDBY: assert property (
    standby_flag_we
    |=> standby_state_flag == $past(standby_flag_wdata))
    else $error("standby flag write lost");

  COV_IDLE_EXPIRE: cover property (idle_expire ##1 !mgmt_int_out_n);
  COV_DLY_FIRE:    cover property (dly_fire);
  COV_BOTH:        cover property (dly_fire && pend_ext_reg && pend_sw_reg);
  COV_REGATE:      cover property (!ctrl.output_gate ##1 ctrl.output_gate ##1 !mgmt_int_out_n);
  COV_EVT_RELOAD:  cover property (reload_evt && idle_run_reg && tick_slow);

endmodule : mgmt_interrupt_idle_timers

// File: logic/mgmt_timer_pkg.sv
package mgmt_timer_pkg;

  // clock and time base
  localparam int unsigned CLK_PERIOD_NS  = 10;
  localparam int unsigned MS_NS          = 1000000;
  localparam int unsigned MS_CYCLES      = MS_NS / CLK_PERIOD_NS;
  localparam int unsigned SLOW_TICK_S    = 8;
  localparam int unsigned SLOW_TICK_MS   = SLOW_TICK_S * 1000;
  localparam int unsigned EXT_MIN_US     = 32;

  localparam int unsigned COUNT_W        = 8;
  localparam int unsigned IRQ_W          = 16;
  // irq 1, 3..12, 14, 15 take part in reloads
  localparam logic [15:0] IRQ_EVENT_MASK = 16'hdffa;

  localparam logic [7:0]  COUNT_RST      = 8'h00;
  localparam logic [3:0]  STATUS_RST     = 4'h0;
  localparam logic        OUT_N_RST      = 1'h1;

  typedef struct packed {
    logic output_gate;
    logic countdown_freeze;
    logic idle_timer_int_enable;
    logic sw_ext_group_enable;
    logic ext_pin_request_enable;
  } ctrl_t;

  typedef struct packed {
    logic activity_event_global_enable;
    logic irq_line_reload_enable;
    logic cpu_intr_reload_enable;
    logic ring_indicate_reload_enable;
    logic nonmaskable_reload_enable;
    logic suspend_pins_reload_enable;
    logic mgmt_int_reload_enable;
    logic ext_request_reload_enable;
  } reload_en_t;

  typedef struct packed {
    logic idle_timer_status;
    logic sw_ext_group_status;
    logic ext_source_status;
    logic sw_source_status;
  } status_t;

  typedef enum logic [0:0] {
    DLY_IDLE  = 1'b0,
    DLY_COUNT = 1'b1
  } dly_state_t;

endpackage : mgmt_timer_pkg

// File: logic/tick_divider.sv
`timescale 1ns/100ps
module tick_divider #(
  parameter int unsigned MS_CYCLES    = mgmt_timer_pkg::MS_CYCLES,
  parameter int unsigned SLOW_TICK_MS = mgmt_timer_pkg::SLOW_TICK_MS
) (
  input  wire logic mclk,
  input  wire logic rst_n,
  output logic      tick_ms,
  output logic      tick_slow
);

  logic [31:0] cyc_reg;
  logic [31:0] ms_reg;

  // free running: a timer started mid-period sees its first tick early by up to one period
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cyc_reg <= 32'h0;
      tick_ms <= 1'b0;
    end else if (cyc_reg == 32'(MS_CYCLES - 1)) begin
      cyc_reg <= 32'h0;
      tick_ms <= 1'b1;
    end else begin
      cyc_reg <= cyc_reg + 32'h1;
      tick_ms <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ms_reg    <= 32'h0;
      tick_slow <= 1'b0;
    end else if (tick_ms && ms_reg == 32'(SLOW_TICK_MS - 1)) begin
      ms_reg    <= 32'h0;
      tick_slow <= 1'b1;
    end else begin
      if (tick_ms) begin
        ms_reg <= ms_reg + 32'h1;
      end
      tick_slow <= 1'b0;
    end
  end

endmodule : tick_divider

// File: testbench/host_cpu_model.sv
`timescale 1ns/100ps
module host_cpu_model (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic mgmt_int_out_n,
  output int        int_count
);
  logic line_was_n;

  // one handler entry per falling edge; a held low line is not a new entry
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      line_was_n <= 1'b1;
      int_count  <= 0;
    end else begin
      line_was_n <= mgmt_int_out_n;
      if (line_was_n && !mgmt_int_out_n) begin
        int_count <= int_count + 1;
      end
    end
  end
endmodule : host_cpu_model

// File: testbench/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  localparam int unsigned MSC  = 10;
  localparam int unsigned STMS = 4;
  localparam int unsigned SLOW = MSC * STMS;
  logic mclk, rst_n, sw_req, sb_we, sb_wd, cpu_intr, nmi, ring_n, bat_low_n, button_n;
  logic activity_n, ext_pin_n, hw_req, trap, out_n, sb_flag;
  logic [7:0] idle_init, delay_init, idle_count, delay_count, dly;
  logic [15:0] irq_lines, irq_pick;
  logic [3:0] st;
  mgmt_timer_pkg::ctrl_t      ctrl;
  mgmt_timer_pkg::reload_en_t reload_en;
  mgmt_timer_pkg::status_t    status_clear, status;
  logic [3:0] irq_ok [13] = '{1, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 14, 15};
  logic [7:0] en_tab [9] = '{8'hc0, 8'ha0, 8'h90, 8'h88, 8'h84, 8'h84, 8'h82, 8'h81, 8'h00};
  int int_count, k, seed_unused;
  int exp_q[$];
  int miscompares = 0;
  int checks_done = 0;

  assign st = status;

  // reference for the line one cycle ahead: gate and every live request level
  always @(posedge mclk) begin
    #2;
    if (rst_n === 1'b1) begin
      if (exp_q.size() > 0) check(8'(out_n), 8'(exp_q.pop_front()), "line vs model");
      exp_q.push_back(int'(!(ctrl.output_gate && (st[3] && ctrl.idle_timer_int_enable
                      || st[2] && ctrl.sw_ext_group_enable || hw_req || trap))));
    end
  end

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  mgmt_interrupt_idle_timers #(.MS_CYCLES(MSC), .SLOW_TICK_MS(STMS)) dut_u (
    .mclk(mclk), .rst_n(rst_n), .ctrl(ctrl), .software_request_bit(sw_req),
    .standby_flag_we(sb_we), .standby_flag_wdata(sb_wd), .idle_init_count(idle_init),
    .delay_init_count(delay_init), .reload_en(reload_en), .irq_lines(irq_lines),
    .cpu_intr(cpu_intr), .nmi(nmi), .serial_ring_indicate_pin_n(ring_n),
    .battery_low_pin_n(bat_low_n), .suspend_resume_button_pin_n(button_n),
    .system_activity_pin_n(activity_n), .external_request_pin_n(ext_pin_n),
    .hw_mgmt_request(hw_req), .local_trap_request(trap), .status_clear(status_clear),
    .mgmt_int_out_n(out_n), .status(status), .standby_state_flag(sb_flag),
    .idle_count(idle_count), .delay_count(delay_count));

  host_cpu_model host_u (.mclk(mclk), .rst_n(rst_n), .mgmt_int_out_n(out_n),
                         .int_count(int_count));

  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : step

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic final_report;
    if (miscompares == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : final_report

  // bounded wait for one status flag; k tells how long it took
  task automatic wait_stat(input int b, input int limit);
    k = 0;
    while (st[b] !== 1'b1 && k < limit) begin
      step(1);
      k++;
    end
    check(8'(st[b]), 8'h01, "flag never set");
  endtask : wait_stat

  task automatic clr_status;
    status_clear = 4'hf;
    step(1);
    status_clear = 4'h0;
    step(1);
  endtask : clr_status

  task automatic sw_pulse;
    sw_req = 1'b1;
    step(1);
    sw_req = 1'b0;
  endtask : sw_pulse

  task automatic drive_evt(input int i, input logic on);
    case (i)
      0: irq_lines = on ? irq_pick : 16'h0000;
      1: cpu_intr = on;
      2: ring_n = !on;
      3: nmi = on;
      4: bat_low_n = !on;
      5: button_n = !on;
      6: hw_req = on;
      7: ext_pin_n = !on;
      default: activity_n = !on;
    endcase
  endtask : drive_evt

  initial begin
    seed_unused = $urandom(75642);
    {rst_n, sw_req, sb_we, sb_wd, cpu_intr, nmi, hw_req, trap} = 8'h00;
    {ring_n, bat_low_n, button_n, activity_n, ext_pin_n} = 5'h1f;
    {idle_init, delay_init, irq_lines} = 32'h0000_0000;
    ctrl = 5'h00;
    reload_en = 8'h00;
    status_clear = 4'h0;
    step(20);
    rst_n = 1'b1;
    step(1);
    check(8'(out_n), 8'h01, "out after reset");
    check(8'(st), 8'h00, "status after reset");
    check(idle_count | delay_count, 8'h00, "counts after reset");
    ctrl.output_gate = 1'b1;
    hw_req = 1'b1;
    step(1);
    check(8'(out_n), 8'h00, "gated request");
    ctrl.output_gate = 1'b0;
    step(1);
    check(8'(out_n), 8'h01, "gate cleared");
    ctrl.output_gate = 1'b1;
    step(1);
    check(8'(out_n), 8'h00, "gate set again");
    hw_req = 1'b0;
    step(1);
    ctrl.output_gate = 1'b0;
    hw_req = 1'b1;
    trap = 1'b1;
    step(1);
    check(8'(out_n), 8'h01, "clear against set");
    hw_req = 1'b0;
    ctrl.output_gate = 1'b1;
    trap = 1'b1;
    step(1);
    check(8'(out_n), 8'h00, "trap request");
    trap = 1'b0;
    step(1);
    check(8'(int_count), 8'h03, "handler entries");
    ctrl.sw_ext_group_enable = 1'b1;
    dly = 8'($urandom_range(4, 1));
    delay_init = dly;
    step(1);
    sw_pulse();
    check(delay_count, dly, "delay loaded");
    wait_stat(2, (dly + 2) * MSC);
    check(8'(k >= (dly - 1) * MSC), 8'h01, "delay too short");
    check(8'(st), 8'h05, "software fire flags");
    step(1);
    check(8'(out_n), 8'h00, "delayed interrupt");
    step(3 * MSC);
    check(8'(st), 8'h05, "flags sticky");
    clr_status();
    check(8'(st), 8'h00, "flags cleared");
    ctrl.ext_pin_request_enable = 1'b1;
    delay_init = 8'h03;
    ext_pin_n = 1'b0;  // held until the handler sees the flag, well past the minimum
    step(2);
    sw_pulse();
    wait_stat(2, 5 * MSC);
    check(8'(st), 8'h07, "both sources flagged");
    ext_pin_n = 1'b1;
    clr_status();
    ctrl.ext_pin_request_enable = 1'b0;
    ext_pin_n = 1'b0;
    step(6 * MSC);
    check(delay_count | 8'(st), 8'h00, "pin without its enable");
    ext_pin_n = 1'b1;
    ctrl.sw_ext_group_enable = 1'b0;
    sw_pulse();
    step(6 * MSC);
    check(delay_count | 8'(st), 8'h00, "group disabled");
    ctrl.sw_ext_group_enable = 1'b1;
    activity_n = 1'b0;
    sw_pulse();
    step(6 * MSC);
    check(delay_count | 8'(st), 8'h03, "delay held by activity");
    activity_n = 1'b1;
    wait_stat(2, 5 * MSC);
    clr_status();
    ctrl.sw_ext_group_enable = 1'b0;
    idle_init = 8'h02;
    ctrl.idle_timer_int_enable = 1'b1;
    step(1);
    check(idle_count, 8'h02, "idle start");
    ctrl.countdown_freeze = 1'b1;
    step(3 * SLOW);
    check(idle_count | 8'(st), 8'h02, "frozen");
    ctrl.countdown_freeze = 1'b0;
    wait_stat(3, 4 * SLOW);
    check(8'(k >= SLOW), 8'h01, "idle too short");
    check(idle_count, 8'h02, "idle reloaded on expiry");
    step(1);
    check(8'(out_n), 8'h00, "idle interrupt");
    clr_status();
    for (int i = 0; i < 9; i++) begin
      irq_pick = 16'h0001 << irq_ok[$urandom_range(12, 0)];
      reload_en = en_tab[i];
      drive_evt(i, 1'b1);
      step(3 * SLOW);
      check(idle_count | 8'(st[3]), 8'h02, "event reload");
      drive_evt(i, 1'b0);
    end
    clr_status();
    reload_en = 8'h7f;
    cpu_intr = 1'b1;
    wait_stat(3, 4 * SLOW);
    cpu_intr = 1'b0;
    clr_status();
    reload_en = 8'hc0;
    irq_lines = 16'h2005;
    wait_stat(3, 4 * SLOW);
    irq_lines = 16'h0000;
    clr_status();
    sb_we = 1'b1;
    sb_wd = 1'b1;
    step(1);
    sb_we = 1'b0;
    check(8'(sb_flag), 8'h01, "standby flag");
    check(8'(st), 8'h00, "standby flag side effect");
    final_report();
  end

  // the run needs about 1800 cycles; a hang is cut well beyond that
  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    final_report();
  end
endmodule : tb_top
